/* File: ddslc_pkg.sv */
// constants, field layouts and carrier types of the dual converter serial load control
// assumes a 32-bit apb slave on pclk and a serial link clocked by its own sclk
package ddslc_pkg;

	// converter code width and code landmarks
	localparam int CODE_W = 16;
	localparam logic [15:0] ZERO_CODE = 16'h0000;
	localparam logic [15:0] FULL_CODE = 16'hFFFF;
	localparam logic [15:0] FULL_CODE_12B = 16'h0FFF;
	localparam logic [15:0] MID_CODE = 16'h8000;

	// serial frame
	localparam int FRAME_W = 24;
	localparam logic [4:0] FRAME_BITS = 5'h18;
	localparam logic [4:0] FRAME_LAST_BIT = 5'h17;
	localparam int SCLK_MAX_MHZ = 50;

	// apb register byte offsets
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_STATUS = 8'h04;
	localparam logic [7:0] ADDR_INPUT_A = 8'h08;
	localparam logic [7:0] ADDR_INPUT_B = 8'h0C;
	localparam logic [7:0] ADDR_CONV_A = 8'h10;
	localparam logic [7:0] ADDR_CONV_B = 8'h14;
	localparam logic [7:0] ADDR_LAST_FRAME = 8'h18;

	// control register fields and reset value
	localparam int CTRL_SYNC_BIT = 0;
	localparam int CTRL_EXTREF_BIT = 1;
	localparam logic [1:0] CTRL_RST = 2'h0;

	// pin synchroniser slots and their values under reset
	localparam int PIN_N = 5;
	localparam int PIN_LOAD = 0;
	localparam int PIN_RSTLVL = 1;
	localparam int PIN_GAIN = 2;
	localparam int PIN_FSEL = 3;
	localparam int PIN_TGL = 4;
	localparam logic [4:0] SYNC_RST_VAL = 5'h09;

	// hold pattern whose three set bits keep the converter registers at the reset code for three cycles after release
	localparam logic [2:0] HOLD_RST = 3'h7;

	typedef enum logic {
		LOAD_ASYNC,
		LOAD_SYNC
	} ddslc_load_mode_t;

	typedef struct packed {
		logic [3:0] spare_hi;
		logic readback;
		logic spare_lo;
		logic sel_b;
		logic sel_a;
		logic [15:0] code;
	} ddslc_frame_t;

	typedef struct packed {
		logic [7:0] frame_count;
		logic reset_hold;
		logic reset_level;
		logic span_x2;
		logic pend_b;
		logic pend_a;
		logic init_done;
	} ddslc_status_t;

	typedef struct packed {
		logic [15:0] code_a;
		logic [15:0] code_b;
		logic span_x2;
	} ddslc_dac_out_t;

endpackage

/* File: ddslc_top.sv */
// dual converter front end: serial frame intake, load strobe, reset and apb register file
// assumes the host drives sclk, frame_sel_n and serial_in as a spi master; pins are async to pclk
//
// Function
// - serial output changes on rising serial clock, valid at the following falling edge
// - serial output carries daisy-chain data or readback register contents
// - load strobe works in asynchronous pulse mode or synchronous frame-end mode
// - load strobe low copies pending input registers into converter registers, both together
// - span select pin sets one or two times reference for both channels
// - serial input sampled on falling serial clock edges; host keeps clock at or below 50 MHz
// - frame select low opens frame; next 24 falling edges fill 24-bit shift register
// - reset input acts asynchronously on its falling edge, independent of serial clock
// - load strobe ignored while reset input is low
// - reset loads input and converter registers with zero scale or midscale
// - power-on initialisation does not finish while reset input stays low
// - power-up code is zero scale or midscale per reset level select
// - reference pin driven by internal reference unless external reference chosen
// - code 0x0000 is zero code, 0xFFFF full scale at 16 bits
// - codes are straight binary, full range of the resolution
//
// The register addresses and the APB slave port were decided locally.
`timescale 1ns/1ps
module ddslc_top (
	// apb slave
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// serial link
	input wire logic sclk,
	input wire logic frame_sel_n,
	input wire logic serial_in,
	output logic serial_out,
	output logic serial_out_oe_n,
	// device pins
	input wire logic load_strobe_n,
	input wire logic dac_reset_n,
	input wire logic reset_level_select,
	input wire logic gain_select,
	// converter side
	output ddslc_pkg::ddslc_dac_out_t dac_out,
	output logic ref_out_en_n,
	output logic init_done
);
	import ddslc_pkg::*;

	// link domain: counter is cleared by the frame signal itself, since sclk may stop between frames
	logic lnk_clr;
	logic [4:0] bit_cnt_r;
	logic [23:0] shift_r;
	logic [23:0] word_r;
	logic frame_tgl_r;
	logic serial_out_r;
	logic last_edge;
	logic out_bit;
	logic rb_bit;
	logic [23:0] rb_word_r;
	logic rb_armed_r;

	assign lnk_clr = frame_sel_n | ~presetn;
	assign last_edge = ~frame_sel_n & (bit_cnt_r == FRAME_LAST_BIT);

	// the count stops at 24, so the readback index below never wraps
	always_ff @(negedge sclk or posedge lnk_clr) begin
		if (lnk_clr) begin
			bit_cnt_r <= 5'h00;
		end else if (bit_cnt_r != FRAME_BITS) begin
			bit_cnt_r <= bit_cnt_r + 5'h01;
		end
	end

	// shifting continues past 24 edges so that surplus bits fall out for a chained device
	always_ff @(negedge sclk or negedge presetn) begin
		if (!presetn) begin
			shift_r <= 24'h000000;
		end else if (!frame_sel_n) begin
			shift_r <= {shift_r[22:0], serial_in};
		end
	end

	// the word is held still for a whole frame after capture, so pclk may read it after the toggle
	always_ff @(negedge sclk or negedge presetn) begin
		if (!presetn) begin
			word_r <= 24'h000000;
			frame_tgl_r <= 1'b0;
		end else if (last_edge) begin
			word_r <= {shift_r[22:0], serial_in};
			frame_tgl_r <= ~frame_tgl_r;
		end
	end

	// bit (23 - count) leaves on each rising edge, from the chain or from the readback word
	assign rb_bit = (bit_cnt_r < FRAME_BITS) ? rb_word_r[FRAME_LAST_BIT - bit_cnt_r] : 1'b0;
	assign out_bit = rb_armed_r ? rb_bit : shift_r[23];

	always_ff @(posedge sclk or negedge presetn) begin
		if (!presetn) begin
			serial_out_r <= 1'b0;
		end else begin
			serial_out_r <= out_bit;
		end
	end

	assign serial_out = serial_out_r;
	assign serial_out_oe_n = frame_sel_n;

	// pclk domain: two-flop synchronisers for every outside level except dac_reset_n
	logic [PIN_N-1:0] pin_raw;
	logic [PIN_N-1:0] pin_s;

	assign pin_raw[PIN_LOAD] = load_strobe_n;
	assign pin_raw[PIN_RSTLVL] = reset_level_select;
	assign pin_raw[PIN_GAIN] = gain_select;
	assign pin_raw[PIN_FSEL] = frame_sel_n;
	assign pin_raw[PIN_TGL] = frame_tgl_r;

	// reset values equal the idle pin levels, so no false strobe edge follows reset
	genvar g;
	generate
		for (g = 0; g < PIN_N; g++) begin : g_sync
			logic meta_r;
			logic sync_r;
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					meta_r <= SYNC_RST_VAL[g];
					sync_r <= SYNC_RST_VAL[g];
				end else begin
					meta_r <= pin_raw[g];
					sync_r <= meta_r;
				end
			end
			assign pin_s[g] = sync_r;
		end
	endgenerate

	// frame completion and load strobe edge
	logic tgl_seen_r;
	logic load_strobe_n_prev_r;
	logic frame_done;
	logic load_strobe_n_fall;
	logic load_strobe_n_low;
	ddslc_frame_t frm;

	// a frame counts only once the select line is back high, so the readback word
	// never changes under a running frame, even one stretched for a daisy chain
	assign frame_done = (pin_s[PIN_TGL] ^ tgl_seen_r) & pin_s[PIN_FSEL];
	assign load_strobe_n_fall = load_strobe_n_prev_r & ~pin_s[PIN_LOAD];
	assign load_strobe_n_low = ~pin_s[PIN_LOAD];
	assign frm = ddslc_frame_t'(word_r);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tgl_seen_r <= 1'b0;
			load_strobe_n_prev_r <= 1'b1;
		end else begin
			if (pin_s[PIN_FSEL]) begin
				tgl_seen_r <= pin_s[PIN_TGL];
			end
			load_strobe_n_prev_r <= pin_s[PIN_LOAD];
		end
	end

	// reset hold: either reset asserts it at once, release waits for the level pin to settle
	logic rst_any_n;
	logic [2:0] hold_r;
	logic hold;
	logic init_done_r;
	logic [15:0] rst_code;

	// three edges of hold give the level pin its two synchroniser stages first
	assign rst_any_n = presetn & dac_reset_n;
	assign hold = hold_r[2];
	assign rst_code = pin_s[PIN_RSTLVL] ? MID_CODE : ZERO_CODE;

	always_ff @(posedge pclk or negedge rst_any_n) begin
		if (!rst_any_n) begin
			hold_r <= HOLD_RST;
		end else begin
			hold_r <= {hold_r[1:0], 1'b0};
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			init_done_r <= 1'b0;
		end else if (!hold) begin
			init_done_r <= 1'b1;
		end
	end

	assign init_done = init_done_r;

	// control register
	logic [1:0] ctrl_r;
	ddslc_load_mode_t load_mode;
	logic load_ev;

	assign load_mode = ctrl_r[CTRL_SYNC_BIT] ? LOAD_SYNC : LOAD_ASYNC;

	// async mode follows the strobe; a strobe tied low keeps the update path open
	assign load_ev = ~hold & ((load_mode == LOAD_SYNC) ? (frame_done & load_strobe_n_low)
		: (load_strobe_n_fall | load_strobe_n_low));

	// apb decode
	logic setup_ph;
	logic access_ph;
	logic hit_ctrl;
	logic hit_status;
	logic hit_in_a;
	logic hit_in_b;
	logic hit_conv_a;
	logic hit_conv_b;
	logic hit_last;
	logic addr_ok;
	logic wr_ctrl;
	logic [1:0] wr_apb;
	logic [31:0] rd_mux;
	logic [31:0] prdata_r;
	logic pslverr_r;

	assign setup_ph = psel & ~penable;
	assign access_ph = psel & penable;
	assign hit_ctrl = (paddr == ADDR_CTRL);
	assign hit_status = (paddr == ADDR_STATUS);
	assign hit_in_a = (paddr == ADDR_INPUT_A);
	assign hit_in_b = (paddr == ADDR_INPUT_B);
	assign hit_conv_a = (paddr == ADDR_CONV_A);
	assign hit_conv_b = (paddr == ADDR_CONV_B);
	assign hit_last = (paddr == ADDR_LAST_FRAME);
	assign addr_ok = hit_ctrl | hit_status | hit_in_a | hit_in_b | hit_conv_a | hit_conv_b
		| hit_last;
	assign wr_ctrl = access_ph & pwrite & hit_ctrl;
	assign wr_apb[0] = access_ph & pwrite & hit_in_a;
	assign wr_apb[1] = access_ph & pwrite & hit_in_b;

	// per channel input register, converter register and pending flag
	logic [1:0][15:0] in_v;
	logic [1:0][15:0] conv_v;
	logic [1:0] pend_v;
	logic [1:0] sel_v;

	assign sel_v = {frm.sel_b, frm.sel_a};

	genvar c;
	generate
		for (c = 0; c < 2; c++) begin : g_chan
			logic [15:0] in_r;
			logic [15:0] in_nxt;
			logic [15:0] conv_r;
			logic [15:0] conv_nxt;
			logic pend_r;
			logic pend_nxt;
			logic wr_frame;
			logic upd;

			assign wr_frame = frame_done & ~frm.readback & sel_v[c];
			// a frame met by a live strobe goes straight through, so sync mode shows its code
			assign upd = load_ev & (pend_r | wr_frame);
			// straight binary codes pass untouched, 0x0000 zero and 0xFFFF full scale
			assign in_nxt = hold ? rst_code
				: wr_frame ? frm.code
				: wr_apb[c] ? pwdata[15:0] : in_r;
			assign conv_nxt = hold ? rst_code
				: upd ? (wr_frame ? frm.code : in_r) : conv_r;
			// an apb write in the cycle of an update stays pending for the next strobe
			assign pend_nxt = hold ? 1'b0
				: ((pend_r & ~upd) | (wr_frame & ~load_ev) | wr_apb[c]);

			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					in_r <= ZERO_CODE;
					conv_r <= ZERO_CODE;
					pend_r <= 1'b0;
				end else begin
					in_r <= in_nxt;
					conv_r <= conv_nxt;
					pend_r <= pend_nxt;
				end
			end

			assign in_v[c] = in_r;
			assign conv_v[c] = conv_r;
			assign pend_v[c] = pend_r;
		end
	endgenerate

	// readback word and frame bookkeeping; updated only after a frame ends, while sclk is idle
	logic [7:0] frames_r;
	logic [23:0] last_frame_r;
	logic span_x2_r;
	logic ref_en_n_r;
	ddslc_dac_out_t dac_out_r;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rb_armed_r <= 1'b0;
			rb_word_r <= 24'h000000;
			frames_r <= 8'h00;
			last_frame_r <= 24'h000000;
		end else if (frame_done) begin
			rb_armed_r <= frm.readback;
			rb_word_r <= {8'h00, frm.sel_a ? conv_v[0] : conv_v[1]};
			frames_r <= frames_r + 8'h01;
			last_frame_r <= word_r;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_r <= CTRL_RST;
		end else if (wr_ctrl) begin
			ctrl_r <= pwdata[1:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			span_x2_r <= 1'b0;
			ref_en_n_r <= 1'b0;
			dac_out_r <= '0;
		end else begin
			// both channels and the span move on the same edge
			span_x2_r <= pin_s[PIN_GAIN];
			ref_en_n_r <= ctrl_r[CTRL_EXTREF_BIT];
			dac_out_r <= '{code_a: conv_v[0], code_b: conv_v[1], span_x2: span_x2_r};
		end
	end

	assign dac_out = dac_out_r;
	assign ref_out_en_n = ref_en_n_r;

	// status and read mux
	ddslc_status_t status;

	assign status = '{
		frame_count: frames_r,
		reset_hold: hold,
		reset_level: pin_s[PIN_RSTLVL],
		span_x2: span_x2_r,
		pend_b: pend_v[1],
		pend_a: pend_v[0],
		init_done: init_done_r
	};

	assign rd_mux = hit_ctrl ? {30'h0, ctrl_r}
		: hit_status ? {18'h0, status}
		: hit_in_a ? {16'h0000, in_v[0]}
		: hit_in_b ? {16'h0000, in_v[1]}
		: hit_conv_a ? {16'h0000, conv_v[0]}
		: hit_conv_b ? {16'h0000, conv_v[1]}
		: hit_last ? {8'h00, last_frame_r} : 32'h00000000;

	// read data is captured in the setup cycle so the access cycle can finish at once
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_r <= 32'h00000000;
			pslverr_r <= 1'b0;
		end else if (setup_ph) begin
			prdata_r <= pwrite ? 32'h00000000 : rd_mux;
			pslverr_r <= ~addr_ok;
		end
	end

	assign prdata = prdata_r;
	// zero wait states: every access ends at its first access edge
	assign pready = 1'b1;
	assign pslverr = pslverr_r & access_ph;

endmodule

/* File: ddslc_assertions.sv */
// port assertions for the dual converter load control
// assumes binding into ddslc_top; pclk domain, presetn async low
`timescale 1ns/1ps
module ddslc_chk (
	// apb
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	// pins
	input wire logic frame_sel_n,
	input wire logic serial_out_oe_n,
	input wire logic load_strobe_n,
	input wire logic dac_reset_n,
	input wire logic reset_level_select,
	input wire logic gain_select,
	input wire ddslc_pkg::ddslc_dac_out_t dac_out,
	input wire logic ref_out_en_n,
	input wire logic init_done
);
	import ddslc_pkg::*;
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	wire logic [15:0] rst_code = reset_level_select ? MID_CODE : ZERO_CODE;
	wire logic ext_ref = pwdata[CTRL_EXTREF_BIT];
	chk_oe_frame: assert property (serial_out_oe_n == frame_sel_n)
		else $error("output enable off frame");
	chk_span_pin: assert property ((init_done && $stable(gain_select))[*5] |->
		dac_out.span_x2 == gain_select)
		else $error("span mismatch");
	chk_ref_ctrl: assert property (psel && penable && pwrite && paddr == ADDR_CTRL |->
		##2 ref_out_en_n == $past(ext_ref, 2))
		else $error("reference enable mismatch");
	chk_init_rise: assert property ($rose(presetn) && dac_reset_n |->
		!init_done ##[3:5] init_done)
		else $error("init done timing");
	chk_hold_init: assert property (!dac_reset_n && !init_done |=> !init_done)
		else $error("init done during reset");
	chk_reset_code: assert property ((!dac_reset_n && $stable(reset_level_select))[*5] |->
		dac_out.code_a == rst_code && dac_out.code_b == rst_code)
		else $error("reset code wrong");
	chk_load_ignored: assert property ((!dac_reset_n && $stable(reset_level_select))[*5] |=>
		$stable(dac_out.code_a) && $stable(dac_out.code_b))
		else $error("code moved in reset");
	chk_conv_a: assert property (psel && !penable && paddr == ADDR_CONV_A |=> ##1
		dac_out.code_a == $past(prdata) && $past(prdata) < 32'h10000)
		else $error("conv a readback");
	chk_conv_b: assert property (psel && !penable && paddr == ADDR_CONV_B |=> ##1
		dac_out.code_b == $past(prdata) && $past(prdata) < 32'h10000)
		else $error("conv b readback");
	cov_load: cover property ($fell(load_strobe_n) && dac_reset_n);
	cov_reset: cover property ($fell(dac_reset_n));
	cov_frame: cover property ($rose(frame_sel_n));
endmodule
bind ddslc_top ddslc_chk chk_i (.*);

/* File: ddslc_host.sv */
// serial host model: 24-bit frames, clock runs only inside frames
// assumes the device samples on falling sclk and shifts out on rising sclk
`timescale 1ns/1ps
module ddslc_host (
	// serial link
	output logic sclk,
	output logic frame_sel_n,
	output logic serial_in,
	input wire logic serial_out
);
	import ddslc_pkg::*;
	initial begin
		sclk = 1'b0;
		frame_sel_n = 1'b1;
		serial_in = 1'b0;
	end
	// 48 ns period keeps the link under its ceiling
	task automatic xfer(input logic [23:0] w, output logic [23:0] rx);
		// start off the pclk edge so the link phase bears no relation to it
		#7;
		frame_sel_n = 1'b0;
		#24;
		for (int i = FRAME_W - 1; i >= 0; i--) begin
			sclk = 1'b1;
			serial_in = w[i];
			#24;
			sclk = 1'b0;
			rx[i] = serial_out;
			#24;
		end
		frame_sel_n = 1'b1;
		serial_in = ~w[0];
	endtask
endmodule

/* File: tb.sv */
// self-checking bench for the dual converter load control
// assumes ddslc_host as serial master and apb tasks on pclk
`timescale 1ns/1ps
module tb;
	import ddslc_pkg::*;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata, q;
	logic pready, pslverr, sclk, frame_sel_n, serial_in, serial_out, serial_out_oe_n;
	logic load_strobe_n = 1'b1;
	logic dac_reset_n = 1'b1;
	logic reset_level_select = 1'b0;
	logic gain_select = 1'b0;
	ddslc_dac_out_t dac_out;
	logic ref_out_en_n, init_done, last_err;
	logic [23:0] r;
	int num_errors = 0;
	int checked = 0;
	always #20 pclk = ~pclk;
	ddslc_host hst (.sclk(sclk), .frame_sel_n(frame_sel_n), .serial_in(serial_in),
		.serial_out(serial_out));
	ddslc_top uut (.*);
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			$display("Error %0t: got %h expected %h", $time, got, exp);
			num_errors++;
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge pclk);
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		q = prdata;
		last_err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(q, exp);
	endtask
	task automatic frame(input logic [23:0] w);
		hst.xfer(w, r);
		cyc(8);
	endtask
	task automatic conclude;
		if (num_errors == 0 && checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	initial begin
		#200000;
		num_errors++;
		conclude();
	end
	initial begin
		cyc(6);
		presetn <= 1'b1;
		cyc(8);
		chk(ref_out_en_n, 32'h0);
		rd(ADDR_CONV_A, 32'h0);
		frame(24'h011234);
		rd(ADDR_INPUT_A, 32'h1234);
		rd(ADDR_CONV_A, 32'h0);
		frame(24'h03FFFF);
		chk(r, 32'h011234);
		load_strobe_n <= 1'b0;
		cyc(2);
		load_strobe_n <= 1'b1;
		cyc(6);
		chk({dac_out.code_a, dac_out.code_b}, 32'hFFFFFFFF);
		frame(24'h080000);
		frame(24'h000000);
		chk(r, 32'h00FFFF);
		load_strobe_n <= 1'b0;
		frame(24'h01ABCD);
		rd(ADDR_CONV_A, 32'hABCD);
		apb(1'b1, ADDR_CTRL, 32'h1);
		frame(24'h020FFF);
		rd(ADDR_CONV_B, 32'h0FFF);
		load_strobe_n <= 1'b1;
		apb(1'b1, ADDR_CTRL, 32'h2);
		cyc(1);
		chk(ref_out_en_n, 32'h1);
		reset_level_select <= 1'b1;
		frame(24'h014321);
		dac_reset_n <= 1'b0;
		cyc(2);
		load_strobe_n <= 1'b0;
		cyc(4);
		load_strobe_n <= 1'b1;
		rd(ADDR_INPUT_A, 32'h8000);
		rd(ADDR_CONV_B, 32'h8000);
		dac_reset_n <= 1'b1;
		cyc(8);
		rd(ADDR_CONV_A, 32'h8000);
		gain_select <= 1'b1;
		cyc(6);
		chk(dac_out.span_x2, 32'h1);
		rd(ADDR_LAST_FRAME, 32'h00014321);
		apb(1'b1, ADDR_INPUT_B, 32'h00005A5A);
		rd(ADDR_INPUT_B, 32'h00005A5A);
		load_strobe_n <= 1'b0;
		cyc(2);
		load_strobe_n <= 1'b1;
		cyc(6);
		chk({dac_out.code_a, dac_out.code_b}, 32'h80005A5A);
		rd(ADDR_STATUS, 32'h000001D9);
		apb(1'b0, 8'h1C, 32'h0);
		chk({q[30:0], last_err}, 32'h1);
		presetn <= 1'b0;
		dac_reset_n <= 1'b0;
		cyc(6);
		presetn <= 1'b1;
		cyc(10);
		chk(init_done, 32'h0);
		dac_reset_n <= 1'b1;
		cyc(8);
		chk(init_done, 32'h1);
		rd(ADDR_CONV_A, 32'h8000);
		conclude();
	end
endmodule
